//--- rtl/esmc_defines.vh
// Constants for the energy save mode controller
// What this block does
// - Saver key held about one second moves standby into energy saver.
// - Panel-off idle timer, default 60 s, enters energy saver.
// - Energy saver sets fuser 168 C; only saver, power and switch lights stay on.
// - Host print in energy saver raises fuser target; panel lights stay dark.
// - Key, original, feeder lift or bypass sheet wakes to standby; about 3 s.
// - Energy-saver idle timer, default 15 min, enters low power.
// - Low power sets fuser 143 C, else as energy saver; recovery about 40 s.
// - Low power wakes to standby on the same events as energy saver.
// - Auto off used only without printer or scanner; else night modes.
// - Auto-off timer (90 min) or switch press enters auto off.
// - Auto off stops fuser and all but standby rails; saver light off.
// - Only the operation switch leaves auto off; recovery about 360 s.
// - Auto off disable setting blocks timed entry into auto off; switch press still enters.
// - With options, switch or auto-off timer enters night; power stays.
// - Errors, stored data, feeder busy or leftover paper pick night standby.
// - Night states turn off fuser and switch light; main power light only.
// - Night standby keeps system 5 V and 24 V on.
// - Night mode drops system 5 V; host signal moves to night standby.
// - Operation switch leaves either night state for standby.
`ifndef ESMC_DEFINES_VH
`define ESMC_DEFINES_VH
`define ESMC_CLK_MHZ 250
`define ESMC_MS_CYCLES (`ESMC_CLK_MHZ * 1000)
`define ESMC_KEY_HOLD_MS 1000
`define ESMC_PANEL_OFF_S 60
`define ESMC_SAVER_MIN 15
`define ESMC_AUTO_OFF_MIN 90
`define ESMC_REC_SAVER_S 3
`define ESMC_REC_LOW_S 40
`define ESMC_REC_OFF_S 360
`define ESMC_TEMP_STANDBY 8'hB4
`define ESMC_TEMP_SAVER 8'hA8
`define ESMC_TEMP_LOW 8'h8F
`define ESMC_TEMP_OFF 8'h00
`define ESMC_ST_STANDBY 3'h0
`define ESMC_ST_SAVER 3'h1
`define ESMC_ST_LOW 3'h2
`define ESMC_ST_AUTO_OFF 3'h3
`define ESMC_ST_NIGHT_SBY 3'h4
`define ESMC_ST_NIGHT 3'h5
`define ESMC_ST_RECOVER 3'h6
`endif

//--- rtl/esmc_sync.v
// Three-stage pin synchroniser bank with agreement check
`timescale 1ns/1ps
module esmc_sync #(
   parameter WIDTH = 8
) (
   clk,
   rst_n,
   pin_in,
   level
);
   input wire clk;
   input wire rst_n;
   input wire [WIDTH-1:0] pin_in;
   output reg [WIDTH-1:0] level;
   reg [WIDTH-1:0] s1;
   reg [WIDTH-1:0] s2;
   reg [WIDTH-1:0] s3;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         always @(posedge clk)
         begin
            if (!rst_n)
            begin
               s1[i] <= 1'b0;
               s2[i] <= 1'b0;
               s3[i] <= 1'b0;
               level[i] <= 1'b0;
            end
            else
            begin
               s1[i] <= pin_in[i];
               s2[i] <= s1[i];
               s3[i] <= s2[i];
               if (s2[i] == s3[i])
                  level[i] <= s3[i];
            end
         end
      end
   endgenerate
endmodule

//--- rtl/esmc_ctrl.v
// Energy save mode controller top
`timescale 1ns/1ps
`include "esmc_defines.vh"
module esmc_ctrl #(
   parameter [47:0] KEY_HOLD_CYC = `ESMC_KEY_HOLD_MS * `ESMC_MS_CYCLES,
   parameter [47:0] PANEL_OFF_CYC = 48'd1000 * `ESMC_PANEL_OFF_S
      * `ESMC_MS_CYCLES,
   parameter [47:0] SAVER_CYC = 48'd60000 * `ESMC_SAVER_MIN
      * `ESMC_MS_CYCLES,
   parameter [47:0] AUTO_OFF_CYC = 48'd60000 * `ESMC_AUTO_OFF_MIN
      * `ESMC_MS_CYCLES,
   parameter [47:0] REC_SAVER_CYC = 48'd1000 * `ESMC_REC_SAVER_S
      * `ESMC_MS_CYCLES,
   parameter [47:0] REC_LOW_CYC = 48'd1000 * `ESMC_REC_LOW_S
      * `ESMC_MS_CYCLES,
   parameter [47:0] REC_OFF_CYC = 48'd1000 * `ESMC_REC_OFF_S
      * `ESMC_MS_CYCLES
) (
   clk,
   rst_n,
   saver_key,
   op_switch,
   original_in_feeder,
   document_feeder_open,
   bypass_sheet,
   duplex_paper,
   staple_paper,
   host_print,
   job_busy,
   service_call_error,
   image_stored,
   options_present,
   auto_off_disable_setting,
   fuser_target,
   fuser_lamp_en,
   panel_leds_on,
   saver_led,
   power_led,
   op_switch_led,
   system_5v_en,
   system_24v_en,
   standby_5v_rail,
   standby_12v_rail,
   mode,
   recovering
);
   input wire clk;
   input wire rst_n;
   input wire saver_key;
   input wire op_switch;
   input wire original_in_feeder;
   input wire document_feeder_open;
   input wire bypass_sheet;
   input wire duplex_paper;
   input wire staple_paper;
   input wire host_print;
   input wire job_busy;
   input wire service_call_error;
   input wire image_stored;
   input wire options_present;
   input wire auto_off_disable_setting;
   output reg [7:0] fuser_target;
   output reg fuser_lamp_en;
   output reg panel_leds_on;
   output reg saver_led;
   output reg power_led;
   output reg op_switch_led;
   output reg system_5v_en;
   output reg system_24v_en;
   output reg standby_5v_rail;
   output reg standby_12v_rail;
   output reg [2:0] mode;
   output reg recovering;

   // ------------------------------------------------------------
   // Pin synchronisers and edge detect
   // ------------------------------------------------------------
   wire [7:0] pins;
   reg [7:0] pins_d;
   wire key_s;
   wire sw_s;
   wire orig_s;
   wire open_s;
   wire byp_s;
   wire dup_s;
   wire stp_s;
   wire host_s;
   wire sw_press;
   wire key_press;
   wire wake_evt;
   esmc_sync #(
      .WIDTH(8)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .pin_in({host_print, staple_paper, duplex_paper, bypass_sheet,
         document_feeder_open, original_in_feeder, op_switch, saver_key}),
      .level(pins)
   );
   assign key_s = pins[0];
   assign sw_s = pins[1];
   assign orig_s = pins[2];
   assign open_s = pins[3];
   assign byp_s = pins[4];
   assign dup_s = pins[5];
   assign stp_s = pins[6];
   assign host_s = pins[7];
   assign key_press = key_s & ~pins_d[0];
   assign sw_press = sw_s & ~pins_d[1];
   assign wake_evt = key_press | (orig_s & ~pins_d[2])
      | (open_s & ~pins_d[3]) | (byp_s & ~pins_d[4]);

   // ------------------------------------------------------------
   // State and timers
   // ------------------------------------------------------------
   reg [2:0] state;
   reg [2:0] next_state;
   reg [47:0] idle_cnt;
   reg [47:0] key_cnt;
   reg [47:0] rec_cnt;
   reg [47:0] next_rec;
   reg job_d;
   reg host_job;
   wire job_done;
   wire idle;
   wire key_held;
   wire night_busy;
   assign job_done = job_d & ~job_busy;
   assign idle = ~job_busy & ~host_job;
   assign key_held = (key_cnt >= KEY_HOLD_CYC);
   assign night_busy = service_call_error | image_stored | orig_s
      | open_s | dup_s | stp_s;

   always @*
   begin
      next_state = state;
      next_rec = rec_cnt;
      case (state)
         `ESMC_ST_STANDBY:
         begin
            if (sw_press)
            begin
               if (options_present)
                  next_state = night_busy ? `ESMC_ST_NIGHT_SBY
                     : `ESMC_ST_NIGHT;
               else
                  next_state = `ESMC_ST_AUTO_OFF;
            end
            else if (key_held)
               next_state = `ESMC_ST_SAVER;
            else if (idle && idle_cnt >= PANEL_OFF_CYC)
               next_state = `ESMC_ST_SAVER;
         end
         `ESMC_ST_SAVER, `ESMC_ST_LOW:
         begin
            if (wake_evt)
            begin
               next_state = `ESMC_ST_RECOVER;
               next_rec = (state == `ESMC_ST_SAVER) ? REC_SAVER_CYC
                  : REC_LOW_CYC;
            end
            else if (sw_press)
               next_state = options_present ? (night_busy
                  ? `ESMC_ST_NIGHT_SBY : `ESMC_ST_NIGHT)
                  : `ESMC_ST_AUTO_OFF;
            else if (idle && !auto_off_disable_setting
               && idle_cnt >= AUTO_OFF_CYC)
               next_state = options_present ? (night_busy
                  ? `ESMC_ST_NIGHT_SBY : `ESMC_ST_NIGHT)
                  : `ESMC_ST_AUTO_OFF;
            else if (state == `ESMC_ST_SAVER && idle
               && idle_cnt >= SAVER_CYC)
               next_state = `ESMC_ST_LOW;
         end
         `ESMC_ST_AUTO_OFF:
         begin
            if (sw_press)
            begin
               next_state = `ESMC_ST_RECOVER;
               next_rec = REC_OFF_CYC;
            end
         end
         `ESMC_ST_NIGHT_SBY:
         begin
            if (sw_press)
            begin
               next_state = `ESMC_ST_RECOVER;
               next_rec = REC_OFF_CYC;
            end
         end
         `ESMC_ST_NIGHT:
         begin
            if (sw_press)
            begin
               next_state = `ESMC_ST_RECOVER;
               next_rec = REC_OFF_CYC;
            end
            else if (host_s)
               next_state = `ESMC_ST_NIGHT_SBY;
         end
         `ESMC_ST_RECOVER:
         begin
            if (rec_cnt <= 48'd1)
               next_state = `ESMC_ST_STANDBY;
            else
               next_rec = rec_cnt - 48'd1;
         end
         default:
            next_state = `ESMC_ST_STANDBY;
      endcase
   end

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         state <= `ESMC_ST_STANDBY;
         rec_cnt <= 48'd0;
         idle_cnt <= 48'd0;
         key_cnt <= 48'd0;
         pins_d <= 8'h00;
         job_d <= 1'b0;
         host_job <= 1'b0;
      end
      else
      begin
         state <= next_state;
         rec_cnt <= next_rec;
         pins_d <= pins;
         job_d <= job_busy;
         if (host_s && !pins_d[7] && (state == `ESMC_ST_SAVER
            || state == `ESMC_ST_LOW))
            host_job <= 1'b1;
         else if (job_done || state == `ESMC_ST_STANDBY)
            host_job <= 1'b0;
         if (key_s && state == `ESMC_ST_STANDBY)
            key_cnt <= key_held ? key_cnt : key_cnt + 48'd1;
         else
            key_cnt <= 48'd0;
         if (job_done || next_state != state || !idle)
            idle_cnt <= 48'd0;
         else if (idle_cnt != 48'hFFFF_FFFF_FFFF)
            idle_cnt <= idle_cnt + 48'd1;
      end
   end

   // ------------------------------------------------------------
   // Mode outputs
   // ------------------------------------------------------------
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         fuser_target <= `ESMC_TEMP_STANDBY;
         fuser_lamp_en <= 1'b1;
         panel_leds_on <= 1'b1;
         saver_led <= 1'b0;
         power_led <= 1'b1;
         op_switch_led <= 1'b1;
         system_5v_en <= 1'b1;
         system_24v_en <= 1'b1;
         standby_5v_rail <= 1'b1;
         standby_12v_rail <= 1'b1;
         mode <= `ESMC_ST_STANDBY;
         recovering <= 1'b0;
      end
      else
      begin
         mode <= state;
         recovering <= (state == `ESMC_ST_RECOVER);
         power_led <= 1'b1;
         standby_5v_rail <= 1'b1;
         standby_12v_rail <= 1'b1;
         case (state)
            `ESMC_ST_SAVER, `ESMC_ST_LOW:
            begin
               fuser_target <= host_job ? `ESMC_TEMP_STANDBY
                  : (state == `ESMC_ST_SAVER ? `ESMC_TEMP_SAVER
                  : `ESMC_TEMP_LOW);
               fuser_lamp_en <= 1'b1;
               panel_leds_on <= 1'b0;
               saver_led <= 1'b1;
               op_switch_led <= 1'b1;
               system_5v_en <= 1'b1;
               system_24v_en <= 1'b1;
            end
            `ESMC_ST_AUTO_OFF, `ESMC_ST_NIGHT:
            begin
               fuser_target <= `ESMC_TEMP_OFF;
               fuser_lamp_en <= 1'b0;
               panel_leds_on <= 1'b0;
               saver_led <= 1'b0;
               op_switch_led <= 1'b0;
               system_5v_en <= 1'b0;
               system_24v_en <= 1'b0;
            end
            `ESMC_ST_NIGHT_SBY:
            begin
               fuser_target <= `ESMC_TEMP_OFF;
               fuser_lamp_en <= 1'b0;
               panel_leds_on <= 1'b0;
               saver_led <= 1'b0;
               op_switch_led <= 1'b0;
               system_5v_en <= 1'b1;
               system_24v_en <= 1'b1;
            end
            default:
            begin
               fuser_target <= `ESMC_TEMP_STANDBY;
               fuser_lamp_en <= 1'b1;
               panel_leds_on <= 1'b1;
               saver_led <= 1'b0;
               op_switch_led <= 1'b1;
               system_5v_en <= 1'b1;
               system_24v_en <= 1'b1;
            end
         endcase
      end
   end
endmodule

//--- verification/esmc_panel_model.sv
// Panel, sensor and host pin model driving the block's pin inputs
`timescale 1ns/1ps
module esmc_panel_model (
   input wire clk,
   output logic [7:0] pins
);
   initial pins = 8'h00;
   // Pins change only at the falling edge
   task automatic level(input int i, input logic v);
      begin
         @(negedge clk);
         pins[i] = v;
      end
   endtask
endmodule

//--- verification/esmc_ctrl_checker.sv
// Mode output checker for the energy save mode controller
`timescale 1ns/1ps
module esmc_ctrl_checker (
   input wire clk,
   input wire rst_n,
   input wire job_busy,
   input wire options_present,
   input wire [7:0] fuser_target,
   input wire fuser_lamp_en,
   input wire panel_leds_on,
   input wire saver_led,
   input wire power_led,
   input wire op_switch_led,
   input wire system_5v_en,
   input wire system_24v_en,
   input wire standby_5v_rail,
   input wire standby_12v_rail,
   input wire [2:0] mode
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   property p_saver_out;
      mode == 3'h1 && $past(mode) == 3'h1
         |-> !panel_leds_on && saver_led && power_led;
   endproperty
   a_saver_out: assert property (p_saver_out)
      else $error("saver outputs wrong");
   property p_saver_tgt;
      mode == 3'h1 && $past(mode) == 3'h1
         |-> fuser_target == 8'hA8 || (fuser_target == 8'hB4
         && (job_busy || $past(job_busy) || $past(job_busy, 2)));
   endproperty
   a_saver_tgt: assert property (p_saver_tgt)
      else $error("saver target wrong");
   property p_low_tgt;
      mode == 3'h2 && $past(mode) == 3'h2
         |-> saver_led && !panel_leds_on && (fuser_target == 8'h8F
         || (fuser_target == 8'hB4
         && (job_busy || $past(job_busy) || $past(job_busy, 2))));
   endproperty
   a_low_tgt: assert property (p_low_tgt)
      else $error("low power outputs wrong");
   property p_off_out;
      mode == 3'h3 && $past(mode) == 3'h3 |-> !fuser_lamp_en
         && fuser_target == 8'h00 && !system_5v_en && !saver_led
         && standby_5v_rail && standby_12v_rail;
   endproperty
   a_off_out: assert property (p_off_out)
      else $error("auto off outputs wrong");
   property p_off_opt;
      mode == 3'h3 |-> !options_present;
   endproperty
   a_off_opt: assert property (p_off_opt)
      else $error("auto off with options");
   property p_off_exit;
      $past(mode) == 3'h3 && mode != 3'h3 |-> mode == 3'h6;
   endproperty
   a_off_exit: assert property (p_off_exit)
      else $error("auto off left wrongly");
   property p_night_out;
      (mode == 3'h4 || mode == 3'h5) && $past(mode) == mode
         |-> !fuser_lamp_en && !op_switch_led && power_led;
   endproperty
   a_night_out: assert property (p_night_out)
      else $error("night outputs wrong");
   property p_nsby;
      mode == 3'h4 && $past(mode) == 3'h4 |-> system_5v_en && system_24v_en;
   endproperty
   a_nsby: assert property (p_nsby)
      else $error("night standby supplies off");
   property p_night;
      mode == 3'h5 && $past(mode) == 3'h5 |-> !system_5v_en && standby_5v_rail;
   endproperty
   a_night: assert property (p_night)
      else $error("night supplies wrong");
   property p_night_exit;
      $past(mode) == 3'h5 && mode != 3'h5 |-> mode == 3'h6 || mode == 3'h4;
   endproperty
   a_night_exit: assert property (p_night_exit)
      else $error("night left wrongly");
   c_saver: cover property (mode == 3'h1);
   c_off: cover property (mode == 3'h3);
   c_nsby: cover property (mode == 3'h4);
   c_night: cover property (mode == 3'h5);
endmodule
bind esmc_ctrl esmc_ctrl_checker u_chk (.clk, .rst_n, .job_busy,
   .options_present, .fuser_target, .fuser_lamp_en, .panel_leds_on,
   .saver_led, .power_led, .op_switch_led, .system_5v_en, .system_24v_en,
   .standby_5v_rail, .standby_12v_rail, .mode);

//--- verification/testbench.sv
// Self-checking bench for the energy save mode controller
`timescale 1ns/1ps
module testbench;
   localparam int KH = 20, PO = 60, SV = 120, AO = 200;
   localparam int RS = 10, RL = 15, RO = 25;
   logic clk, rst_n, job_busy, sce, img, opt, aod;
   logic [7:0] pins, tgt;
   logic lamp, panel, sled, pled, swled, v5, v24, sb5, sb12, rec;
   logic [2:0] mode;
   int n_errors = 0, comparisons = 0, waited;
   int pk[7] = '{0, 0, 0, 2, 3, 5, 6};
   initial
   begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   esmc_panel_model u_pm (.clk(clk), .pins(pins));
   esmc_ctrl #(.KEY_HOLD_CYC(48'(KH)), .PANEL_OFF_CYC(48'(PO)),
      .SAVER_CYC(48'(SV)), .AUTO_OFF_CYC(48'(AO)), .REC_SAVER_CYC(48'(RS)),
      .REC_LOW_CYC(48'(RL)), .REC_OFF_CYC(48'(RO))) u_esmc_ctrl (
      .clk(clk), .rst_n(rst_n), .saver_key(pins[0]), .op_switch(pins[1]),
      .original_in_feeder(pins[2]), .document_feeder_open(pins[3]),
      .bypass_sheet(pins[4]), .duplex_paper(pins[5]),
      .staple_paper(pins[6]), .host_print(pins[7]), .job_busy(job_busy),
      .service_call_error(sce), .image_stored(img), .options_present(opt),
      .auto_off_disable_setting(aod), .fuser_target(tgt),
      .fuser_lamp_en(lamp), .panel_leds_on(panel), .saver_led(sled),
      .power_led(pled), .op_switch_led(swled), .system_5v_en(v5),
      .system_24v_en(v24), .standby_5v_rail(sb5), .standby_12v_rail(sb12),
      .mode(mode), .recovering(rec));
   // ----------------------------------------
   // Compare and wait tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      begin
         comparisons++;
         if (g !== e)
         begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task automatic wait_mode(input logic [2:0] m, input int lim);
      begin
         waited = 0;
         while (mode !== m && waited < lim)
         begin
            @(negedge clk);
            waited++;
         end
         chk("mode", {5'h00, m}, {5'h00, mode});
      end
   endtask
   task automatic wake(input int i, input int r);
      begin
         repeat (4) @(negedge clk);
         u_pm.level(i, 1'b1);
         wait_mode(3'h6, 20);
         chk("recovering", 8'h01, {7'h00, rec});
         u_pm.level(i, 1'b0);
         wait_mode(3'h0, r + 10);
         chk("recovery", 8'h01, {7'h00, waited >= r - 3 && waited <= r + 1});
      end
   endtask
   task give_verdict;
      begin
         $display("comparisons %0d n_errors %0d", comparisons, n_errors);
         if (n_errors == 0 && comparisons > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   initial
   begin
      #(4 * 20000);
      n_errors++;
      $display("Error watchdog expected finish seen timeout");
      give_verdict;
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      {rst_n, job_busy, sce, img, opt, aod} = 6'h00;
      repeat (10) @(negedge clk);
      rst_n = 1;
      chk("target", 8'hB4, tgt);
      u_pm.level(0, 1'b1);
      wait_mode(3'h1, KH + 15);
      chk("hold", 8'h01, {7'h00, waited >= KH});
      chk("target", 8'hA8, tgt);
      chk("panel", 8'h00, {7'h00, panel});
      u_pm.level(0, 1'b0);
      job_busy = 1;
      u_pm.level(7, 1'b1);
      repeat (10) @(negedge clk);
      chk("target", 8'hB4, tgt);
      chk("panel", 8'h00, {7'h00, panel});
      u_pm.level(7, 1'b0);
      job_busy = 0;
      repeat (4) @(negedge clk);
      $display("test saver entry done");
      for (int j = 0; j < 4; j++)
      begin
         if (j > 0)
         begin
            wait_mode(3'h1, PO + 20);
            chk("idle", 8'h01, {7'h00, waited >= PO - 2});
         end
         wake(j == 0 ? 0 : j + 1, RS);
      end
      $display("test saver wake done");
      wait_mode(3'h2, PO + SV + 30);
      chk("target", 8'h8F, tgt);
      wake(4, RL);
      aod = 1;
      wait_mode(3'h2, PO + SV + 30);
      repeat (AO + 20) @(negedge clk);
      chk("mode", 8'h02, {5'h00, mode});
      wake(2, RL);
      aod = 0;
      $display("test low power done");
      wait_mode(3'h3, PO + SV + AO + 50);
      chk("target", 8'h00, tgt);
      u_pm.level(2, 1'b1);
      repeat (10) @(negedge clk);
      chk("mode", 8'h03, {5'h00, mode});
      u_pm.level(2, 1'b0);
      wake(1, RO);
      u_pm.level(1, 1'b1);
      wait_mode(3'h3, 20);
      u_pm.level(1, 1'b0);
      wake(1, RO);
      $display("test auto off done");
      opt = 1;
      for (int k = 0; k < 7; k++)
      begin
         sce = (k == 1);
         img = (k == 2);
         if (k > 2)
            u_pm.level(pk[k], 1'b1);
         repeat (8) @(negedge clk);
         u_pm.level(1, 1'b1);
         wait_mode(k > 0 ? 3'h4 : 3'h5, 20);
         u_pm.level(1, 1'b0);
         if (k == 0)
         begin
            chk("sys5v", 8'h00, {7'h00, v5});
            u_pm.level(7, 1'b1);
            wait_mode(3'h4, 20);
            u_pm.level(7, 1'b0);
            chk("sys24v", 8'h01, {7'h00, v24});
         end
         {sce, img} = 2'h0;
         if (k > 2)
            u_pm.level(pk[k], 1'b0);
         wake(1, RO);
      end
      wait_mode(3'h5, PO + SV + AO + 50);
      wake(1, RO);
      $display("test night done");
      give_verdict;
   end
endmodule
